// >>> dv/sss_motor_model.sv
// Partner: motor speed that falls while the power stage brakes
`timescale 1ns/1ps
module sss_motor_model import sss_pkg::*; #(
  parameter int SPEED_W = 16
) (
  input wire logic clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic kick, // Pulse: spin up
  input wire sss_act_e action_ff, // Braking action
  output logic [SPEED_W-1:0] speed_ff // Speed magnitude
);
  //==========================================
  // Harder braking sheds more speed per cycle
  always_ff @(posedge clk) begin
    if (reset) speed_ff <= '0;
    else if (kick) speed_ff <= SPEED_W'(40);
    else if (action_ff != SSS_ACT_RUN) begin
      if (action_ff == SSS_ACT_ESTOP) speed_ff <= (speed_ff > SPEED_W'(4)) ? speed_ff - SPEED_W'(4) : '0;
      else if (action_ff == SSS_ACT_BRAKE) speed_ff <= (speed_ff > SPEED_W'(2)) ? speed_ff - SPEED_W'(2) : '0;
      else speed_ff <= (speed_ff > SPEED_W'(1)) ? speed_ff - SPEED_W'(1) : '0;
    end
  end
endmodule : sss_motor_model

// >>> dv/sss_stop_select_bench.sv
// Bench: stop selector tests through parameter writes and pins
`timescale 1ns/1ps
module sss_stop_select_bench import sss_pkg::*;;
  logic clk = 0, reset = 1, power_cycle = 0, wr_en = 0, kick = 0;
  logic fwd_prohibit = 0, rev_prohibit = 0, servo_on = 1, main_power_ok = 1;
  sss_wr_s wr = '0;
  logic [15:0] speed_abs, standstill_thr = 16'h0004;
  logic wr_reject_ff, fwd_torque_off_ff, rev_torque_off_ff;
  logic err_cnt_clear_ff, undervoltage_alarm_ff, power_alarm_ff;
  sss_act_e action_ff;
  sss_phase_e phase_ff;
  int miscompares = 0, checked = 0, cycles = 0, n;
  sss_stop_select #(.STEP_CYCLES(4)) dut (.clk, .reset, .power_cycle, .wr_en, .wr, .wr_reject_ff,
    .fwd_prohibit, .rev_prohibit, .servo_on, .main_power_ok, .speed_abs, .standstill_thr,
    .fwd_torque_off_ff, .rev_torque_off_ff, .action_ff, .phase_ff, .err_cnt_clear_ff,
    .undervoltage_alarm_ff, .power_alarm_ff);
  sss_motor_model motor (.clk, .reset, .kick, .action_ff, .speed_ff(speed_abs));
  initial forever #20 clk = ~clk;
  //==========================================
  // Helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic put(input logic [2:0] w, input logic [10:0] v, input logic rej);
    @(posedge clk) wr_en <= 1'b1;
    wr <= '{w, v};
    @(posedge clk) wr_en <= 1'b0;
    @(posedge clk) #1 chk(wr_reject_ff, rej);
  endtask : put
  task automatic wait_ph(input sss_phase_e p);
    for (n = 0; n < 400 && phase_ff !== p; n++) @(posedge clk) #1;
    chk(phase_ff, p);
  endtask : wait_ph
  // Prohibit the directions in dir {fwd, rev}, then expect the torque cuts and action five cycles on
  task automatic prh(input sss_act_e a, input logic [1:0] dir);
    @(posedge clk) {fwd_prohibit, rev_prohibit} <= dir;
    repeat (5) @(posedge clk);
    #1 chk({fwd_torque_off_ff, rev_torque_off_ff}, dir);
    chk(action_ff, a);
    @(posedge clk) {fwd_prohibit, rev_prohibit} <= 2'b00;
    repeat (5) @(posedge clk);
  endtask : prh
  function automatic sss_plan_s plan(input logic [3:0] v);
    plan.decel = v > 7 ? SSS_ACT_ESTOP : (v[0] ? SSS_ACT_FREE : SSS_ACT_BRAKE);
    plan.after = (v > 7 ? v[0] : v[1]) ? SSS_ACT_FREE : SSS_ACT_BRAKE;
    plan.clear_cnt = !(v inside {[4:7]});
  endfunction : plan
  // Spin up, remove servo or supply, follow the phases on to the final phase fin
  task automatic run_stop(input logic pw, input sss_plan_s p, input sss_phase_e fin);
    @(posedge clk) kick <= 1'b1;
    if (pw) main_power_ok <= 1'b0;
    else servo_on <= 1'b0;
    @(posedge clk) kick <= 1'b0;
    wait_ph(SSS_PH_DECEL);
    if (pw) chk(n > 276 && n < 296, 1'b1);
    chk(power_alarm_ff, pw);
    chk({action_ff, err_cnt_clear_ff}, {p.decel, p.clear_cnt});
    wait_ph(SSS_PH_STOPPED);
    chk({action_ff, err_cnt_clear_ff}, {p.after, p.clear_cnt});
    @(posedge clk) servo_on <= 1'b1;
    main_power_ok <= 1'b1;
    // A tripped undervoltage alarm keeps the drive stopped until reset
    wait_ph(fin);
  endtask : run_stop
  task automatic give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  //==========================================
  // Hang guard, about nine times the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      miscompares++;
      give_verdict();
    end
  end
  //==========================================
  // Test sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk) #1 chk({action_ff, phase_ff}, {SSS_ACT_RUN, SSS_PH_IDLE});
    @(posedge clk) fwd_prohibit <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk({fwd_torque_off_ff, action_ff}, {1'b0, SSS_ACT_RUN});
    @(posedge clk) fwd_prohibit <= 1'b0;
    put(SSS_W_PROHIBIT_EN, 11'h000, 1'b0);
    put(SSS_W_PROHIBIT_STOP, 11'h003, 1'b1);
    for (int v = 0; v < 3; v++) begin
      put(SSS_W_PROHIBIT_STOP, 11'(v), 1'b0);
      @(posedge clk) power_cycle <= 1'b1;
      @(posedge clk) power_cycle <= 1'b0;
      prh(v == 0 ? SSS_ACT_BRAKE : v == 1 ? SSS_ACT_FREE : SSS_ACT_ESTOP, {v == 1, v != 1});
    end
    put(SSS_W_PROHIBIT_STOP, 11'h000, 1'b0);
    prh(SSS_ACT_ESTOP, 2'b11);
    $display("test prohibit done");
    for (int v = 0; v < 10; v++) begin
      put(SSS_W_SERVO_OFF, 11'(v), 1'b0);
      run_stop(1'b0, plan(4'(v)), SSS_PH_IDLE);
    end
    put(SSS_W_SERVO_OFF, 11'h00A, 1'b1);
    run_stop(1'b0, plan(4'h9), SSS_PH_IDLE);
    $display("test servo off done");
    put(SSS_W_SERVO_OFF, 11'h000, 1'b0);
    put(SSS_W_POWER_OFF, 11'h008, 1'b0);
    put(SSS_W_HOLD_TIME, 11'h045, 1'b1);
    put(SSS_W_HOLD_TIME, 11'h7D1, 1'b1);
    run_stop(1'b1, plan(4'h8), SSS_PH_IDLE);
    chk(undervoltage_alarm_ff, 1'b0);
    put(SSS_W_UV_ACTION, 11'h002, 1'b1);
    put(SSS_W_UV_ACTION, 11'h000, 1'b0);
    run_stop(1'b1, plan(4'h8), SSS_PH_STOPPED);
    chk(undervoltage_alarm_ff, 1'b1);
    // Mid-run reset clears the sticky trip and returns the drive to idle
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk) #1 chk({undervoltage_alarm_ff, action_ff, phase_ff}, {1'b0, SSS_ACT_RUN, SSS_PH_IDLE});
    $display("test power off done");
    give_verdict();
  end
endmodule : sss_stop_select_bench

// >>> dv/sss_stop_select_properties.sv
// Checker: port-level properties of the stop sequence selector
`timescale 1ns/1ps
module sss_stop_select_checker import sss_pkg::*; #(
  parameter int STEP_CYCLES = 4,
  parameter int SPEED_W = 16
) (
  input wire logic clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic wr_en, // Write strobe
  input wire sss_wr_s wr, // Write data
  input wire logic wr_reject_ff, // Write refused
  input wire logic fwd_prohibit, // Forward pin
  input wire logic servo_on, // Servo pin
  input wire logic main_power_ok, // Supply pin
  input wire logic [SPEED_W-1:0] speed_abs, // Speed
  input wire logic [SPEED_W-1:0] standstill_thr, // Threshold
  input wire logic fwd_torque_off_ff, // Torque cut
  input wire sss_act_e action_ff, // Braking action
  input wire sss_phase_e phase_ff, // Phase
  input wire logic err_cnt_clear_ff, // Counter clear
  input wire logic undervoltage_alarm_ff, // Trip
  input wire logic power_alarm_ff // Power alarm
);
  //==========================================
  // Supply-low cycle count, pin side, so it never undercounts the sync delay
  int low_cnt_ff;
  always_ff @(posedge clk) begin
    if (reset || main_power_ok) low_cnt_ff <= 0;
    else low_cnt_ff <= low_cnt_ff + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_servo_low;
    !servo_on [*5];
  endsequence
  sequence s_enter_stopped;
    $rose(phase_ff == SSS_PH_STOPPED);
  endsequence
  //==========================================
  // Properties
  a_servo_stop: assert property (s_servo_low |-> phase_ff != SSS_PH_IDLE)
    else $error("no stop phase after servo off");
  a_reject_high: assert property (wr_en && wr.which == SSS_W_SERVO_OFF && wr.value > 11'h009 |=> wr_reject_ff)
    else $error("out of range selector accepted");
  a_accept_low: assert property (wr_en && wr.which == SSS_W_POWER_OFF && wr.value <= 11'h009 |=> !wr_reject_ff)
    else $error("legal selector refused");
  a_hold_min: assert property (wr_en && wr.which == SSS_W_HOLD_TIME && wr.value < 11'h046 |=> wr_reject_ff)
    else $error("short hold time accepted");
  a_stop_order: assert property (s_enter_stopped |-> $past(phase_ff) == SSS_PH_DECEL)
    else $error("stopped without deceleration");
  a_standstill: assert property (s_enter_stopped |-> $past(speed_abs) < $past(standstill_thr))
    else $error("stopped above threshold");
  a_estop_clear: assert property (phase_ff == SSS_PH_DECEL && action_ff == SSS_ACT_ESTOP |-> err_cnt_clear_ff)
    else $error("emergency stop without clear");
  a_uv_sticky: assert property (undervoltage_alarm_ff |=> undervoltage_alarm_ff)
    else $error("undervoltage trip dropped");
  a_alarm_delay: assert property ($rose(power_alarm_ff) |-> low_cnt_ff >= 70 * STEP_CYCLES)
    else $error("power alarm too early");
  a_torque_pin: assert property (fwd_torque_off_ff |-> $past(fwd_prohibit, 3))
    else $error("torque cut without prohibit");
endmodule : sss_stop_select_checker
bind sss_stop_select sss_stop_select_checker #(.STEP_CYCLES(STEP_CYCLES), .SPEED_W(SPEED_W)) chk_i (
  .clk, .reset, .wr_en, .wr, .wr_reject_ff, .fwd_prohibit, .servo_on, .main_power_ok, .speed_abs,
  .standstill_thr, .fwd_torque_off_ff, .action_ff, .phase_ff, .err_cnt_clear_ff,
  .undervoltage_alarm_ff, .power_alarm_ff);

// >>> hdl/sss_pkg.sv
// Package: constants and carrier types for the servo stop sequence selector
//==============================================================================
// Function
// - Prohibit stop selector 0: cut prohibited-direction torque, engage dynamic brake.
// - Prohibit stop selector 1: cut prohibited-direction torque, free-run deceleration.
// - Prohibit stop selector 2: cut prohibited-direction torque, emergency stop.
// - Prohibit stop selector accepts 0 to 2, defaults 0, applies after power cycle.
// - Servo-off values 0-3 clear counter; bit0 free-run, bit1 servo-free after stop.
// - Servo-off 8/9 emergency stop, clear counter; 8 brake, 9 free after stop.
// - Main power off uses its own selector, same encoding, range 0-9, default 0.
// - Undervoltage action selector 0 or 1, default 1, alarm trip versus servo off.
// - Power loss alarm after hold time 70-2000 ms, default 70, after power cycle.
// - Prohibit input enable selector 1 ignores both prohibit inputs.
package sss_pkg;

  // Reset values of the stored selectors
  localparam logic [1:0] SSS_PROHIBIT_EN_RST = 2'h1;
  localparam logic [1:0] SSS_PROHIBIT_STOP_RST = 2'h0;
  localparam logic [3:0] SSS_SERVO_OFF_RST = 4'h0;
  localparam logic [3:0] SSS_POWER_OFF_RST = 4'h0;
  localparam logic SSS_UV_ACTION_RST = 1'b1;
  localparam logic [10:0] SSS_HOLD_TIME_RST = 11'h046;
  // Idle pin levels {fwd, rev, servo on, supply ok}, so reset makes no false stop
  localparam logic [3:0] SSS_PIN_IDLE = 4'h3;

  // Ranges of the selectors
  localparam logic [1:0] SSS_PROHIBIT_EN_MAX = 2'h2;
  localparam logic [1:0] SSS_PROHIBIT_EN_OFF = 2'h1;
  localparam logic [1:0] SSS_PROHIBIT_STOP_MAX = 2'h2;
  localparam logic [3:0] SSS_STOP_SEL_MAX = 4'h9;
  localparam logic [10:0] SSS_HOLD_TIME_MIN = 11'h046;
  localparam logic [10:0] SSS_HOLD_TIME_MAX = 11'h7D0;
  localparam logic [3:0] SSS_STOP_ESTOP_BRAKE = 4'h8;
  localparam logic [3:0] SSS_STOP_ESTOP_FREE = 4'h9;
  localparam logic [1:0] SSS_PSTOP_BRAKE = 2'h0;
  localparam logic [1:0] SSS_PSTOP_FREE = 2'h1;

  // Timing: one hold-time step in ns and clocks per step at 25 MHz
  localparam int SSS_CLK_PERIOD_NS = 40;
  localparam int SSS_STEP_NS = 1000000;
  localparam int SSS_STEP_CYCLES = SSS_STEP_NS / SSS_CLK_PERIOD_NS;

  // Braking action of the power stage
  typedef enum logic [3:0] {
    SSS_ACT_RUN = 4'b0001,
    SSS_ACT_BRAKE = 4'b0010,
    SSS_ACT_FREE = 4'b0100,
    SSS_ACT_ESTOP = 4'b1000
  } sss_act_e;

  // Stop sequence phase
  typedef enum logic [2:0] {
    SSS_PH_IDLE = 3'b001,
    SSS_PH_DECEL = 3'b010,
    SSS_PH_STOPPED = 3'b100
  } sss_phase_e;

  // Decoded stop behaviour for one selector value
  typedef struct packed {
    sss_act_e decel;
    sss_act_e after;
    logic clear_cnt;
  } sss_plan_s;

  // Parameter write port
  typedef struct packed {
    logic [2:0] which;
    logic [10:0] value;
  } sss_wr_s;

  localparam logic [2:0] SSS_W_PROHIBIT_EN = 3'h0;
  localparam logic [2:0] SSS_W_PROHIBIT_STOP = 3'h1;
  localparam logic [2:0] SSS_W_SERVO_OFF = 3'h2;
  localparam logic [2:0] SSS_W_POWER_OFF = 3'h3;
  localparam logic [2:0] SSS_W_UV_ACTION = 3'h4;
  localparam logic [2:0] SSS_W_HOLD_TIME = 3'h5;

endpackage : sss_pkg

// >>> hdl/sss_stop_select.sv
// Module: stop sequence selection for drive prohibit, servo off and main power loss
`timescale 1ns/1ps
module sss_stop_select import sss_pkg::*; #(
  parameter int STEP_CYCLES = SSS_STEP_CYCLES,
  parameter int SPEED_W = 16
) (
  input wire logic clk, // 25 MHz clock
  input wire logic reset, // Synchronous, active high
  input wire logic power_cycle, // Pulse: deferred parameters take effect
  input wire logic wr_en, // Pulse: parameter write
  input wire sss_wr_s wr, // Parameter select and value
  output logic wr_reject_ff, // Last write was out of range
  input wire logic fwd_prohibit, // Forward drive prohibit pin
  input wire logic rev_prohibit, // Reverse drive prohibit pin
  input wire logic servo_on, // Servo on command, pin
  input wire logic main_power_ok, // Main supply present, pin
  input wire logic [SPEED_W-1:0] speed_abs, // Measured speed magnitude
  input wire logic [SPEED_W-1:0] standstill_thr, // Standstill threshold
  output logic fwd_torque_off_ff, // Forward torque removed
  output logic rev_torque_off_ff, // Reverse torque removed
  output sss_act_e action_ff, // Power stage braking action
  output sss_phase_e phase_ff, // Stop sequence phase
  output logic err_cnt_clear_ff, // Clear the position error counter
  output logic undervoltage_alarm_ff, // Undervoltage alarm tripped
  output logic power_alarm_ff // Main power alarm declared
);

  //==========================================================================
  // Elaboration checks
  initial begin
    if (STEP_CYCLES < 1) $error("STEP_CYCLES must be at least 1");
    if (SPEED_W < 1) $error("SPEED_W must be at least 1");
  end

  // Decode a ten-value stop selector into its plan
  function automatic sss_plan_s decode_stop(input logic [3:0] sel);
    sss_plan_s p;
    p.clear_cnt = ~sel[2] | sel[3];
    p.decel = sel[0] ? SSS_ACT_FREE : SSS_ACT_BRAKE;
    p.after = sel[1] ? SSS_ACT_FREE : SSS_ACT_BRAKE;
    if (sel == SSS_STOP_ESTOP_BRAKE) begin
      p.decel = SSS_ACT_ESTOP;
      p.after = SSS_ACT_BRAKE;
    end else if (sel == SSS_STOP_ESTOP_FREE) begin
      p.decel = SSS_ACT_ESTOP;
      p.after = SSS_ACT_FREE;
    end
    return p;
  endfunction : decode_stop

  //==========================================================================
  // Pin synchronisers; first stage feeds only the second
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      // Idle levels: servo on and supply present, so no stop or power timer starts on release
      sync1_ff <= SSS_PIN_IDLE;
      sync2_ff <= SSS_PIN_IDLE;
    end else begin
      sync1_ff <= {fwd_prohibit, rev_prohibit, servo_on, main_power_ok};
      sync2_ff <= sync1_ff;
    end
  end
  logic fwd_s;
  logic rev_s;
  logic son_s;
  logic pwr_s;
  assign {fwd_s, rev_s, son_s, pwr_s} = sync2_ff;

  //==========================================================================
  // Stored parameters; pending copies become active on a power cycle
  logic [1:0] pen_pend_ff;
  logic [1:0] pen_ff;
  logic [1:0] pstop_pend_ff;
  logic [1:0] pstop_ff;
  logic [3:0] soff_ff;
  logic [3:0] poff_ff;
  logic uv_sel_ff;
  logic [10:0] hold_pend_ff;
  logic [10:0] hold_ff;
  logic wr_ok;

  // Range check of each write
  always_comb begin
    case (wr.which)
      SSS_W_PROHIBIT_EN: wr_ok = wr.value <= 11'(SSS_PROHIBIT_EN_MAX);
      SSS_W_PROHIBIT_STOP: wr_ok = wr.value <= 11'(SSS_PROHIBIT_STOP_MAX);
      SSS_W_SERVO_OFF: wr_ok = wr.value <= 11'(SSS_STOP_SEL_MAX);
      SSS_W_POWER_OFF: wr_ok = wr.value <= 11'(SSS_STOP_SEL_MAX);
      SSS_W_UV_ACTION: wr_ok = wr.value <= 11'h001;
      SSS_W_HOLD_TIME: wr_ok = wr.value >= SSS_HOLD_TIME_MIN && wr.value <= SSS_HOLD_TIME_MAX;
      default: wr_ok = 1'b0;
    endcase
  end

  // Writes: rejected values leave the stored value in force
  always_ff @(posedge clk) begin
    if (reset) begin
      pen_pend_ff <= SSS_PROHIBIT_EN_RST;
      pstop_pend_ff <= SSS_PROHIBIT_STOP_RST;
      soff_ff <= SSS_SERVO_OFF_RST;
      poff_ff <= SSS_POWER_OFF_RST;
      uv_sel_ff <= SSS_UV_ACTION_RST;
      hold_pend_ff <= SSS_HOLD_TIME_RST;
      wr_reject_ff <= 1'b0;
    end else if (wr_en) begin
      wr_reject_ff <= ~wr_ok;
      if (wr_ok) begin
        case (wr.which)
          SSS_W_PROHIBIT_EN: pen_pend_ff <= wr.value[1:0];
          SSS_W_PROHIBIT_STOP: pstop_pend_ff <= wr.value[1:0];
          SSS_W_SERVO_OFF: soff_ff <= wr.value[3:0];
          SSS_W_POWER_OFF: poff_ff <= wr.value[3:0];
          SSS_W_UV_ACTION: uv_sel_ff <= wr.value[0];
          SSS_W_HOLD_TIME: hold_pend_ff <= wr.value;
          default: ;
        endcase
      end
    end
  end

  // Power-cycle-deferred parameters
  always_ff @(posedge clk) begin
    if (reset) begin
      pen_ff <= SSS_PROHIBIT_EN_RST;
      pstop_ff <= SSS_PROHIBIT_STOP_RST;
      hold_ff <= SSS_HOLD_TIME_RST;
    end else if (power_cycle) begin
      pen_ff <= pen_pend_ff;
      pstop_ff <= pstop_pend_ff;
      hold_ff <= hold_pend_ff;
    end
  end

  //==========================================================================
  // Main power loss timer: counts ms steps while the supply is absent
  logic [$clog2(STEP_CYCLES+1)-1:0] tick_ff;
  logic [10:0] ms_ff;
  always_ff @(posedge clk) begin
    if (reset || pwr_s) begin
      tick_ff <= '0;
      ms_ff <= 11'h000;
      power_alarm_ff <= 1'b0;
    end else if (!power_alarm_ff) begin
      if (tick_ff == $bits(tick_ff)'(STEP_CYCLES - 1)) begin
        tick_ff <= '0;
        ms_ff <= ms_ff + 11'h001;
        if (ms_ff + 11'h001 >= hold_ff) power_alarm_ff <= 1'b1;
      end else begin
        tick_ff <= tick_ff + 1'b1;
      end
    end
  end

  // Alarm action: selector 0 trips the alarm, 1 turns the servo off
  logic pwr_servo_off;
  assign pwr_servo_off = power_alarm_ff & uv_sel_ff;
  always_ff @(posedge clk) begin
    if (reset) undervoltage_alarm_ff <= 1'b0;
    else if (power_alarm_ff && !uv_sel_ff) undervoltage_alarm_ff <= 1'b1;
  end

  //==========================================================================
  // Stop cause and plan; power loss outranks servo off
  logic stop_req;
  sss_plan_s plan;
  assign stop_req = ~son_s | pwr_servo_off | undervoltage_alarm_ff;
  assign plan = decode_stop(power_alarm_ff ? poff_ff : soff_ff);

  logic stand;
  assign stand = speed_abs < standstill_thr;

  // Phase sequencing
  sss_phase_e nxt_phase;
  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      SSS_PH_IDLE: if (stop_req) nxt_phase = SSS_PH_DECEL;
      SSS_PH_DECEL: begin
        if (!stop_req) nxt_phase = SSS_PH_IDLE;
        else if (stand) nxt_phase = SSS_PH_STOPPED;
      end
      SSS_PH_STOPPED: if (!stop_req) nxt_phase = SSS_PH_IDLE;
      default: nxt_phase = SSS_PH_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) phase_ff <= SSS_PH_IDLE;
    else phase_ff <= nxt_phase;
  end

  //==========================================================================
  // Drive prohibit: torque off in the blocked direction
  logic pro_en;
  logic pro_any;
  assign pro_en = pen_ff != SSS_PROHIBIT_EN_OFF;
  assign pro_any = pro_en & (fwd_s | rev_s);
  always_ff @(posedge clk) begin
    if (reset) begin
      fwd_torque_off_ff <= 1'b0;
      rev_torque_off_ff <= 1'b0;
    end else begin
      fwd_torque_off_ff <= pro_en & fwd_s;
      rev_torque_off_ff <= pro_en & rev_s;
    end
  end

  // Braking action and error counter handling
  always_ff @(posedge clk) begin
    if (reset) begin
      action_ff <= SSS_ACT_RUN;
      err_cnt_clear_ff <= 1'b0;
    end else if (nxt_phase == SSS_PH_DECEL) begin
      action_ff <= plan.decel;
      err_cnt_clear_ff <= plan.clear_cnt;
    end else if (nxt_phase == SSS_PH_STOPPED) begin
      action_ff <= plan.after;
      err_cnt_clear_ff <= plan.clear_cnt;
    end else if (pro_any) begin
      err_cnt_clear_ff <= 1'b0;
      case (pstop_ff)
        SSS_PSTOP_BRAKE: action_ff <= SSS_ACT_BRAKE;
        SSS_PSTOP_FREE: action_ff <= SSS_ACT_FREE;
        default: action_ff <= SSS_ACT_ESTOP;
      endcase
    end else begin
      action_ff <= SSS_ACT_RUN;
      err_cnt_clear_ff <= 1'b0;
    end
  end

endmodule : sss_stop_select
